// file: common/lip_pkg.sv
// Purpose: Shared constants and types of the line interface I/O port.
// Assumes: 40 MHz system clock; registers reached over the serial control port.
// Notes:   Offsets are 7-bit register addresses as sent in the first byte.

package lip_pkg;

   // ***************************************************
   // Register addresses
   // ***************************************************
   localparam logic [6:0] ADDR_PIN_WAY_LOW    = 7'h00;
   localparam logic [6:0] ADDR_PIN_WAY_HIGH   = 7'h01;
   localparam logic [6:0] ADDR_LINE0_LOW      = 7'h02;
   localparam logic [6:0] ADDR_LINE3_HIGH     = 7'h09;
   localparam logic [6:0] ADDR_SETUP_REGISTER = 7'h20;

   // ***************************************************
   // Field layout and reset values
   // ***************************************************
   localparam int         PIN_W          = 12;
   localparam int         LOW_W          = 8;
   localparam int         HIGH_W         = 4;
   localparam int         NUM_LINES      = 4;
   localparam int         STROBE_W       = 4;
   localparam int         FIXED_IO_BIT   = 4;
   localparam int         BYTE_BITS      = 8;
   localparam logic [11:0] VALUE_RESET   = 12'h000;
   localparam logic [7:0]  SETUP_RESET   = 8'h00;
   localparam logic [3:0]  HIGH_PAD      = 4'h0;
   localparam logic [3:0]  STROBES_IDLE  = 4'hF;
   localparam logic [3:0]  STROBES_DRIVE = 4'hF;

   // ***************************************************
   // Timing of the strobe scan
   // ***************************************************
   localparam int CLK_MHZ    = 40;
   localparam int STROBE_NS  = 1000;
   localparam int GAP_NS     = 250;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYC    = (GAP_NS * CLK_MHZ + 999) / 1000;

   // ***************************************************
   // Enumerations
   // ***************************************************
   typedef enum logic {lip_scan_gap, lip_scan_strobe} lip_scan_t;
   typedef enum logic {lip_ph_addr, lip_ph_data} lip_phase_t;

   // True when an address names one of the line value bytes.
   function automatic logic lip_is_line(input logic [6:0] a);
      return (a >= ADDR_LINE0_LOW) && (a <= ADDR_LINE3_HIGH);
   endfunction : lip_is_line

   // Line number of a line value byte address.
   function automatic logic [1:0] lip_line_of(input logic [6:0] a);
      logic [6:0] off;
      off = a - ADDR_LINE0_LOW;
      return off[2:1];
   endfunction : lip_line_of

   // High byte of a 12-bit field; the upper nibble reads as zero.
   function automatic logic [7:0] lip_high_byte(input logic [11:0] f);
      return {HIGH_PAD, f[PIN_W-1:LOW_W]};
   endfunction : lip_high_byte

endpackage : lip_pkg

// file: verilog/lip_pin_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk_sys_i.
// Notes:   A change is taken once the second and third stages agree.

`timescale 1ns/1ps

module lip_pin_sync #(
   parameter int W = 19
) (
   // Clock and reset.
   input  wire logic         clk_sys_i,
   input  wire logic         reset_i,
   // Raw and filtered levels.
   input  wire logic [W-1:0] raw_i,
   output logic      [W-1:0] level_o
);

   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
      logic [W-1:0] ff3;
      logic [W-1:0] q;
   } lip_sync_state_t;

   lip_sync_state_t sync_reg;
   lip_sync_state_t sync_next;
   logic [W-1:0]    agree;

   // The first stage feeds only the second, so a metastable bit never reaches logic.
   always_comb begin
      sync_next     = sync_reg;
      agree         = ~(sync_reg.ff2 ^ sync_reg.ff3);
      sync_next.ff1 = raw_i;
      sync_next.ff2 = sync_reg.ff1;
      sync_next.ff3 = sync_reg.ff2;
      sync_next.q   = (agree & sync_reg.ff3) | (~agree & sync_reg.q);
   end

   // State register.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign level_o = sync_reg.q;

endmodule : lip_pin_sync

// file: verilog/lip_serial_port.sv
// Purpose: Byte-framed serial control port giving register reads and writes.
// Assumes: Control clock, data and select already synchronised.
// Notes:   One address byte then one data byte; the select rises between bytes.

`timescale 1ns/1ps

module lip_serial_port (
   // Clock and reset.
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   // Synchronised serial lines.
   input  wire logic       cclk_i,
   input  wire logic       ci_i,
   input  wire logic       sel_n_i,
   output logic            co_o,
   output logic            co_oe_o,
   // Register access.
   output logic            wr_en_o,
   output logic [6:0]      addr_o,
   output logic [7:0]      wr_data_o,
   input  wire logic [7:0] rd_data_i
);

   typedef struct packed {
      lip_pkg::lip_phase_t ph;
      logic                cclk_d;
      logic                sel_d;
      logic [3:0]          cnt;
      logic [7:0]          sh;
      logic                rw;
      logic [6:0]          addr;
      logic [7:0]          osh;
      logic                co;
      logic                co_oe;
      logic                wr;
   } lip_ser_state_t;

   lip_ser_state_t ser_reg;
   lip_ser_state_t ser_next;

   // Bytes shift in MSB first on rising control clock and out on falling edges.
   always_comb begin
      ser_next        = ser_reg;
      ser_next.wr     = 1'b0;
      ser_next.cclk_d = cclk_i;
      ser_next.sel_d  = sel_n_i;
      if (ser_reg.sel_d && !sel_n_i) begin
         ser_next.cnt = 4'h0;
         if (ser_reg.ph == lip_pkg::lip_ph_data && ser_reg.rw) begin
            ser_next.co_oe = 1'b1;
            ser_next.co    = rd_data_i[7];
            ser_next.osh   = {rd_data_i[6:0], 1'b0};
         end
      end else if (!sel_n_i) begin
         if (!ser_reg.cclk_d && cclk_i && ser_reg.cnt != 4'hF) begin
            ser_next.sh  = {ser_reg.sh[6:0], ci_i};
            ser_next.cnt = ser_reg.cnt + 4'h1;
         end
         if (ser_reg.cclk_d && !cclk_i && ser_reg.co_oe) begin
            ser_next.co  = ser_reg.osh[7];
            ser_next.osh = {ser_reg.osh[6:0], 1'b0};
         end
      end else if (!ser_reg.sel_d && sel_n_i) begin
         // A byte with a wrong pulse count is dropped and the port waits for an address.
         ser_next.co_oe = 1'b0;
         ser_next.ph    = lip_pkg::lip_ph_addr;
         if (ser_reg.cnt == 4'(lip_pkg::BYTE_BITS)) begin
            if (ser_reg.ph == lip_pkg::lip_ph_addr) begin
               ser_next.rw   = ser_reg.sh[7];
               ser_next.addr = ser_reg.sh[6:0];
               ser_next.ph   = lip_pkg::lip_ph_data;
            end else if (!ser_reg.rw) begin
               ser_next.wr = 1'b1;
            end
         end
      end
   end

   // State register.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ser_reg <= '0;
      end else begin
         ser_reg <= ser_next;
      end
   end

   assign co_o      = ser_reg.co;
   assign co_oe_o   = ser_reg.co_oe;
   assign wr_en_o   = ser_reg.wr;
   assign addr_o    = ser_reg.addr;
   assign wr_data_o = ser_reg.sh;

   chk_write_single : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en_o |=> !wr_en_o) else $error("Write strobe lasted more than one cycle.");

endmodule : lip_serial_port

// file: verilog/lip_io_port.sv
// Purpose: Twelve-pin line interface port with four select strobes.
// Assumes: Registers are reached over the serial control port.
// Notes:   Control clock must stay well below a tenth of the system clock.

`timescale 1ns/1ps

module lip_io_port (
   // Clock and reset.
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Serial control port.
   input  wire logic        ctl_clk_i,
   input  wire logic        ctl_data_i,
   input  wire logic        ctl_sel_n_i,
   output logic             ctl_data_o,
   output logic             ctl_data_oe_o,
   // Line pins.
   input  wire logic [11:0] line_pin_i,
   output logic      [11:0] line_pin_o,
   output logic      [11:0] line_pin_oe_o,
   // Select strobes, active low in dynamic mode.
   input  wire logic [3:0]  slic_select_strobe_n_i,
   output logic      [3:0]  slic_select_strobe_n_o,
   output logic      [3:0]  slic_select_strobe_n_oe_o
);

   // ***************************************************
   // Local constants and state
   // ***************************************************
   localparam int         SYNC_W      = 19;
   localparam int         STROBE_HOLD = lip_pkg::STROBE_CYC;
   localparam logic [7:0] STROBE_INIT = 8'(lip_pkg::STROBE_CYC - 1);
   localparam logic [7:0] GAP_INIT    = 8'(lip_pkg::GAP_CYC - 1);

   typedef struct packed {
      logic [11:0]                       dir;
      logic [lip_pkg::NUM_LINES-1:0][11:0] val;
      logic [7:0]                        setup;
      lip_pkg::lip_scan_t                st;
      logic [1:0]                        ch;
      logic [7:0]                        cnt;
      logic [11:0]                       io_out;
      logic [11:0]                       io_oe;
      logic [3:0]                        sb_out;
      logic [3:0]                        sb_oe;
   } lip_core_state_t;

   lip_core_state_t core_reg;
   lip_core_state_t core_next;

   logic [SYNC_W-1:0] sync_level;
   logic [11:0]       pin_lvl;
   logic [3:0]        sb_lvl;
   logic              cclk_s;
   logic              ci_s;
   logic              sel_n_s;
   logic              wr_en;
   logic [6:0]        reg_addr;
   logic [7:0]        wr_data;
   logic [7:0]        rd_byte;
   logic              static_mode;
   logic [1:0]        wr_line;
   logic [1:0]        rd_line;

   // ***************************************************
   // Input synchronisers
   // ***************************************************

   // All pins and control lines share one filtered synchroniser bank.
   lip_pin_sync #(
      .W (SYNC_W)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .raw_i     ({ctl_clk_i, ctl_data_i, ctl_sel_n_i, slic_select_strobe_n_i, line_pin_i}),
      .level_o   (sync_level)
   );

   // Split the filtered bank back into its groups.
   assign pin_lvl = sync_level[lip_pkg::PIN_W-1:0];
   assign sb_lvl  = sync_level[lip_pkg::PIN_W+lip_pkg::STROBE_W-1:lip_pkg::PIN_W];
   assign sel_n_s = sync_level[SYNC_W-3];
   assign ci_s    = sync_level[SYNC_W-2];
   assign cclk_s  = sync_level[SYNC_W-1];

   // ***************************************************
   // Serial control port
   // ***************************************************

   // The port decodes the address byte and hands over one data byte.
   lip_serial_port u_serial (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .cclk_i    (cclk_s),
      .ci_i      (ci_s),
      .sel_n_i   (sel_n_s),
      .co_o      (ctl_data_o),
      .co_oe_o   (ctl_data_oe_o),
      .wr_en_o   (wr_en),
      .addr_o    (reg_addr),
      .wr_data_o (wr_data),
      .rd_data_i (rd_byte)
   );

   // ***************************************************
   // Register read path
   // ***************************************************

   // Unmapped addresses read as zero.
   always_comb begin
      rd_byte = 8'h00;
      rd_line = lip_pkg::lip_line_of(reg_addr);
      if (reg_addr == lip_pkg::ADDR_PIN_WAY_LOW) begin
         rd_byte = core_reg.dir[lip_pkg::LOW_W-1:0];
      end else if (reg_addr == lip_pkg::ADDR_PIN_WAY_HIGH) begin
         rd_byte = lip_pkg::lip_high_byte(core_reg.dir);
      end else if (reg_addr == lip_pkg::ADDR_SETUP_REGISTER) begin
         rd_byte = core_reg.setup;
      end else if (lip_pkg::lip_is_line(reg_addr)) begin
         if (reg_addr[0]) begin
            rd_byte = lip_pkg::lip_high_byte(core_reg.val[rd_line]);
         end else begin
            rd_byte = core_reg.val[rd_line][lip_pkg::LOW_W-1:0];
         end
      end
   end

   // ***************************************************
   // Core next-state logic
   // ***************************************************

   // Writes are applied first, then pin capture overlays the input bits, so a
   // sampled pin level wins over a software write to an input bit.
   always_comb begin
      core_next   = core_reg;
      static_mode = core_reg.setup[lip_pkg::FIXED_IO_BIT];
      wr_line     = lip_pkg::lip_line_of(reg_addr);
      if (wr_en) begin
         if (reg_addr == lip_pkg::ADDR_PIN_WAY_LOW) begin
            core_next.dir[lip_pkg::LOW_W-1:0] = wr_data;
         end else if (reg_addr == lip_pkg::ADDR_PIN_WAY_HIGH) begin
            core_next.dir[lip_pkg::PIN_W-1:lip_pkg::LOW_W] = wr_data[lip_pkg::HIGH_W-1:0];
         end else if (reg_addr == lip_pkg::ADDR_SETUP_REGISTER) begin
            core_next.setup = wr_data;
         end else if (lip_pkg::lip_is_line(reg_addr)) begin
            if (reg_addr[0]) begin
               core_next.val[wr_line][lip_pkg::PIN_W-1:lip_pkg::LOW_W] = wr_data[lip_pkg::HIGH_W-1:0];
            end else begin
               core_next.val[wr_line][lip_pkg::LOW_W-1:0] = wr_data;
            end
         end
      end
      if (!static_mode) begin
         // Strobe scan: a gap, then one line's strobe for the hold time.
         case (core_reg.st)
            lip_pkg::lip_scan_gap: begin
               if (core_reg.cnt == 8'h00) begin
                  core_next.st  = lip_pkg::lip_scan_strobe;
                  core_next.cnt = STROBE_INIT;
               end else begin
                  core_next.cnt = core_reg.cnt - 8'h01;
               end
            end
            lip_pkg::lip_scan_strobe: begin
               if (core_reg.cnt == 8'h00) begin
                  // Last strobe cycle: sample the inputs of the selected line.
                  core_next.val[core_reg.ch] = (core_next.val[core_reg.ch] & core_reg.dir)
                                             | (pin_lvl & ~core_reg.dir);
                  core_next.ch  = core_reg.ch + 2'h1;
                  core_next.st  = lip_pkg::lip_scan_gap;
                  core_next.cnt = GAP_INIT;
               end else begin
                  core_next.cnt = core_reg.cnt - 8'h01;
               end
            end
            default: begin
               core_next.st  = lip_pkg::lip_scan_gap;
               core_next.cnt = GAP_INIT;
            end
         endcase
      end else begin
         // Static mode follows the pins every cycle; line 3 is left unused.
         core_next.st     = lip_pkg::lip_scan_gap;
         core_next.cnt    = GAP_INIT;
         core_next.val[0] = (core_next.val[0] & core_reg.dir)
                          | (pin_lvl & ~core_reg.dir);
         core_next.val[2][lip_pkg::STROBE_W-1:0] =
            (core_next.val[2][lip_pkg::STROBE_W-1:0] & core_reg.val[1][lip_pkg::STROBE_W-1:0])
          | (sb_lvl & ~core_reg.val[1][lip_pkg::STROBE_W-1:0]);
      end
      // Pin drivers.
      core_next.io_oe = core_next.dir;
      if (core_next.setup[lip_pkg::FIXED_IO_BIT]) begin
         core_next.io_out = core_next.val[0];
         core_next.sb_out = core_next.val[2][lip_pkg::STROBE_W-1:0];
         core_next.sb_oe  = core_next.val[1][lip_pkg::STROBE_W-1:0];
      end else begin
         // The next line's value is set up during the gap, ahead of its strobe.
         core_next.io_out = core_next.val[core_next.ch];
         core_next.sb_oe  = lip_pkg::STROBES_DRIVE;
         if (core_next.st == lip_pkg::lip_scan_strobe) begin
            core_next.sb_out = ~(4'h1 << core_next.ch);
         end else begin
            core_next.sb_out = lip_pkg::STROBES_IDLE;
         end
      end
   end

   // ***************************************************
   // State register
   // ***************************************************

   // High nibbles reset to zero as well, a legal choice for undefined bits.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         core_reg        <= '0;
         core_reg.val    <= {lip_pkg::NUM_LINES{lip_pkg::VALUE_RESET}};
         core_reg.setup  <= lip_pkg::SETUP_RESET;
         core_reg.st     <= lip_pkg::lip_scan_gap;
         core_reg.cnt    <= GAP_INIT;
         core_reg.sb_out <= lip_pkg::STROBES_IDLE;
         core_reg.sb_oe  <= lip_pkg::STROBES_DRIVE;
      end else begin
         core_reg <= core_next;
      end
   end

   // Every pin output comes straight from the state register.
   assign line_pin_o                = core_reg.io_out;
   assign line_pin_oe_o             = core_reg.io_oe;
   assign slic_select_strobe_n_o    = core_reg.sb_out;
   assign slic_select_strobe_n_oe_o = core_reg.sb_oe;

   // ***************************************************
   // Checks
   // ***************************************************

   chk_dir_low_write : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && reg_addr == lip_pkg::ADDR_PIN_WAY_LOW |=> line_pin_oe_o[7:0] == $past(wr_data))
      else $error("Direction low byte did not reach the pin enables.");

   chk_dir_high_write : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && reg_addr == lip_pkg::ADDR_PIN_WAY_HIGH |=> line_pin_oe_o[11:8] == $past(wr_data[3:0]))
      else $error("Direction high nibble did not reach the pin enables.");

   chk_mode_select : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && reg_addr == lip_pkg::ADDR_SETUP_REGISTER |=> static_mode == $past(wr_data[4]))
      else $error("Mode bit did not follow the setup write.");

   chk_one_strobe : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !static_mode |-> $countones(slic_select_strobe_n_o ^ lip_pkg::STROBES_IDLE) <= 1)
      else $error("More than one strobe active.");

   chk_strobe_width : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $fell(&slic_select_strobe_n_o) && !static_mode && !wr_en
      |-> ##STROBE_HOLD (&slic_select_strobe_n_o))
      else $error("Strobe did not last its hold time.");

   chk_dyn_capture : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !static_mode && !wr_en && core_reg.st == lip_pkg::lip_scan_strobe && core_reg.cnt == 8'h00
      |=> ((core_reg.val[$past(core_reg.ch)] ^ $past(pin_lvl)) & ~core_reg.dir) == 12'h000)
      else $error("Dynamic input capture lost a pin level.");

   chk_static_follow : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      static_mode && !wr_en |=> ((core_reg.val[0] ^ $past(pin_lvl)) & ~core_reg.dir) == 12'h000)
      else $error("Static inputs did not follow the pins.");

   chk_static_drive : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      static_mode && !wr_en |=> line_pin_o == core_reg.val[0] && line_pin_oe_o == core_reg.dir)
      else $error("Static outputs not driven from line 0.");

   chk_strobe_pins : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      static_mode && !wr_en |=> slic_select_strobe_n_oe_o == core_reg.val[1][3:0]
                             && slic_select_strobe_n_o == core_reg.val[2][3:0])
      else $error("Static strobe pins not steered by lines 1 and 2.");

   chk_strobe_input : assert property (@(posedge clk_sys_i) disable iff (reset_i)
      static_mode && !wr_en
      |=> ((core_reg.val[2][3:0] ^ $past(sb_lvl)) & ~core_reg.val[1][3:0]) == 4'h0)
      else $error("Static strobe inputs not stored in line 2.");

endmodule : lip_io_port

// file: verif/lip_slic_model.sv
// Purpose: Behavioural model of the four line circuits on the shared pins.
// Assumes: A circuit drives the pins while its strobe is low.
// Notes:   Released pins show the inverse of the last value, never a held copy.

`timescale 1ns/1ps

module lip_slic_model (
   // Strobes in, pin drive out.
   input  wire logic [3:0]  strobe_n_i,
   output logic      [11:0] drive_o
);
   logic [11:0] last_val = 12'h000;

   // The selected circuit answers with its own pattern; the upper nibble names it.
   always @(strobe_n_i) begin
      drive_o = ~last_val;
      for (int ch = 0; ch < 4; ch++) begin
         if (strobe_n_i[ch] === 1'b0) begin
            drive_o = {4'(ch + 5), 8'hC3};
         end
      end
      last_val = drive_o;
   end
endmodule : lip_slic_model

// file: verif/line_interface_io_port_tb_top.sv
// Purpose: Self-checking bench for the line interface port.
// Assumes: Serial clock of 16 system clocks, far below the filter limit.
// Notes:   Pin levels follow the port's drive enables; the model or bench sets every pin the port does not enable.

`timescale 1ns/1ps

module line_interface_io_port_tb_top;
   logic        clk_sys_i   = 1'b0;
   logic        reset_i     = 1'b1;
   logic        ctl_clk     = 1'b0;
   logic        ci          = 1'b0;
   logic        ctl_sel_n   = 1'b1;
   logic        co;
   logic        co_oe;
   logic        oe_seen     = 1'b0;
   logic [11:0] pin_i, pin_o, pin_oe, slic_drv;
   logic [3:0]  stb_i, stb_o, stb_oe;
   logic [3:0]  tb_strobe   = 4'hF;
   int          errors      = 0;
   int          check_count = 0;

   // Wire levels: whoever enables its driver sets the pin.
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & slic_drv);
   assign stb_i = (stb_oe & stb_o) | (~stb_oe & tb_strobe);

   lip_io_port uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ctl_clk_i(ctl_clk), .ctl_data_i(ci),
      .ctl_sel_n_i(ctl_sel_n), .ctl_data_o(co), .ctl_data_oe_o(co_oe), .line_pin_i(pin_i), .line_pin_o(pin_o),
      .line_pin_oe_o(pin_oe), .slic_select_strobe_n_i(stb_i), .slic_select_strobe_n_o(stb_o),
      .slic_select_strobe_n_oe_o(stb_oe));
   lip_slic_model slics (.strobe_n_i(stb_o), .drive_o(slic_drv));

   // Clock generation.
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic end_of_test();
      if (errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // Inputs always move one nanosecond after the edge.
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : step

   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One framed byte; the answer bit is taken just before each rising serial clock.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      ctl_sel_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         ci = tx[i];
         step(8);
         rx[i] = co;
         oe_seen = co_oe;
         ctl_clk = 1'b1;
         step(8);
         ctl_clk = 1'b0;
      end
      step(8);
      ctl_sel_n = 1'b1;
      step(8);
   endtask : xfer

   task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] rx;
      xfer({1'b0, a}, rx);
      xfer(d, rx);
   endtask : reg_wr

   task automatic reg_rd(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] rx;
      xfer({1'b1, a}, rx);
      check({11'h000, oe_seen}, 12'h000);
      xfer(8'h00, rx);
      check({11'h000, oe_seen}, 12'h001);
      check({11'h000, co_oe}, 12'h000);
      check({4'h0, rx}, {4'h0, exp});
   endtask : reg_rd

   // Reset values, including an unmapped address. The scan runs from reset with every
   // pin an input, so the line values already hold each circuit's pattern.
   task automatic t_reset();
      logic [7:0] exp;
      for (int a = 0; a < 11; a++) begin
         exp = 8'h00;
         if (a >= 2 && a <= 9) begin
            exp = a[0] ? 8'(4 + a / 2) : 8'hC3;
         end
         reg_rd(7'(a), exp);
      end
      reg_rd(lip_pkg::ADDR_SETUP_REGISTER, 8'h00);
      check(pin_oe, 12'h000);
   endtask : t_reset

   // A byte of seven clocks after a write address is dropped; the port waits for an address.
   task automatic t_refused();
      logic [7:0] rx;
      xfer({1'b0, lip_pkg::ADDR_PIN_WAY_LOW}, rx);
      ctl_sel_n = 1'b0;
      ci = 1'b1;
      for (int i = 0; i < 7; i++) begin
         step(8);
         ctl_clk = 1'b1;
         step(8);
         ctl_clk = 1'b0;
      end
      step(8);
      ctl_sel_n = 1'b1;
      step(8);
      reg_rd(lip_pkg::ADDR_PIN_WAY_LOW, 8'h00);
   endtask : t_refused

   // Dynamic output through the strobe of line 1.
   task automatic t_dyn_out();
      int n;
      n = 0;
      reg_wr(lip_pkg::ADDR_PIN_WAY_LOW, 8'hFF);
      reg_wr(lip_pkg::ADDR_PIN_WAY_HIGH, 8'h00);
      check(pin_oe, 12'h0FF);
      reg_wr(7'h04, 8'hA5);
      while (stb_o !== 4'hD && n < 400) begin
         step(1);
         n++;
      end
      step(2);
      check(pin_o & 12'h0FF, 12'h0A5);
      check({8'h00, stb_o}, 12'h00D);
   endtask : t_dyn_out

   // Dynamic capture: the input nibbles of lines 2 and 3 come from their own circuits.
   task automatic t_dyn_in();
      step(250);
      reg_rd(7'h07, 8'h07);
      reg_rd(7'h09, 8'h08);
   endtask : t_dyn_in

   // Static mode with two strobe pins as outputs and two as inputs.
   task automatic t_static();
      tb_strobe = 4'hC;
      reg_wr(lip_pkg::ADDR_SETUP_REGISTER, 8'h10);
      reg_wr(7'h04, 8'h03);
      reg_wr(7'h06, 8'h02);
      reg_wr(7'h02, 8'h3C);
      check(pin_o & 12'h0FF, 12'h03C);
      check({8'h00, stb_oe}, 12'h003);
      check({8'h00, stb_o & 4'h3}, 12'h002);
      reg_rd(7'h03, 8'h05);
      reg_rd(7'h06, 8'h0E);
   endtask : t_static

   // Main sequence.
   initial begin
      step(16);
      reset_i = 1'b0;
      step(8);
      t_reset();
      t_refused();
      t_dyn_out();
      t_dyn_in();
      t_static();
      end_of_test();
   end

   // Watchdog against a hung handshake.
   initial begin
      repeat (30000) @(posedge clk_sys_i);
      errors++;
      end_of_test();
   end
endmodule : line_interface_io_port_tb_top
